// file: shared/pzv_pkg.sv
// Package: offsets, event codes and register map of the page zero vector unit
package pzv_pkg;
  // ==========================================================
  // Vector page layout
  localparam logic [11:0] OFS_PREV_SP = 12'h02C;
  localparam logic [11:0] OFS_RING0_TOP = 12'h03C;
  localparam logic [11:0] OFS_TRACE = 12'h040;
  localparam logic [11:0] OFS_ARITH = 12'h044;
  localparam logic [11:0] OFS_XRING_SP = 12'h048;
  localparam logic [11:0] OFS_GATE = 12'h04C;
  localparam logic [11:0] OFS_BKPT = 12'h050;
  localparam logic [11:0] OFS_SW_TOP = 12'hFFF;
  localparam logic [11:0] OFS_MP_INTR = 12'h008;
  localparam logic [11:0] OFS_SYSEXC = 12'h00C;
  localparam logic [11:0] OFS_DEADLOCK = 12'h010;
  localparam logic [11:0] OFS_ICB = 12'h014;
  localparam logic [11:0] OFS_IOREG = 12'h018;
  localparam logic [11:0] OFS_VVALID = 12'h01C;
  localparam logic [11:0] OFS_HARDERR = 12'h020;
  localparam int RING_W = 3;
  localparam int SEG_LSB = 29;
  localparam logic [2:0] MAX_RING = 3'h4;
  // ==========================================================
  // Event codes
  typedef enum logic [3:0] {
    PZV_EV_NONE = 4'h0,
    PZV_EV_INTR = 4'h1,
    PZV_EV_SYSEXC = 4'h2,
    PZV_EV_DEADLOCK = 4'h3,
    PZV_EV_VVALID = 4'h4,
    PZV_EV_HARDERR = 4'h5,
    PZV_EV_TRACE = 4'h6,
    PZV_EV_ARITH = 4'h7,
    PZV_EV_BKPT = 4'h8,
    PZV_EV_XCALL = 4'h9
  } pzv_event_t;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_EN = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  localparam logic [7:0] REG_LAST_ADDR = 8'h14;
  localparam logic [7:0] REG_LAST_TGT = 8'h18;
  localparam logic [7:0] REG_ISP = 8'h1C;
  localparam int CTRL_MP = 0;
  localparam int CTRL_IOREG = 1;
  localparam int CTRL_HARDERR = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_W = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Shared functions
  function automatic logic [31:0] pzv_page_addr(input logic [2:0] ring, input logic [11:0] ofs);
    pzv_page_addr = {ring, {(SEG_LSB - 12){1'b0}}, ofs};
  endfunction : pzv_page_addr
  function automatic logic pzv_ring0_only(input logic [11:0] ofs);
    pzv_ring0_only = (ofs <= OFS_RING0_TOP);
  endfunction : pzv_ring0_only
endpackage : pzv_pkg

// file: shared/pzv_mem_if.sv
// Interface: vector page memory port between the sequencer and the memory master
`timescale 1ns/1ps
interface pzv_mem_if;
  logic req;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic done;
  logic [31:0] rdata;
  modport seq (output req, output we, output addr, output wdata, input done, input rdata);
  modport mem (input req, input we, input addr, input wdata, output done, output rdata);
endinterface : pzv_mem_if

// file: rtl/pzv_mem_port.sv
// Memory port: one word read or write toward the memory system
`timescale 1ns/1ps
module pzv_mem_port
  import pzv_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  pzv_mem_if.mem mif,
  output logic mem_req_r,
  output logic mem_we_r,
  output logic [31:0] mem_addr_r,
  output logic [31:0] mem_wdata_r,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  logic busy_r;
  logic done_r;
  logic [31:0] rdata_r;

  assign mif.done = done_r;
  assign mif.rdata = rdata_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= 32'h0;
      mem_wdata_r <= 32'h0;
      done_r <= 1'b0;
      rdata_r <= 32'h0;
    end else if (ce) begin
      done_r <= 1'b0;
      if (!busy_r && mif.req && !done_r) begin
        busy_r <= 1'b1;
        mem_req_r <= 1'b1;
        mem_we_r <= mif.we;
        mem_addr_r <= {mif.addr[31:2], 2'b00};
        mem_wdata_r <= mif.wdata;
      end else if (busy_r && mem_ack) begin
        busy_r <= 1'b0;
        mem_req_r <= 1'b0;
        done_r <= 1'b1;
        rdata_r <= mem_rdata;
      end
    end
  end
endmodule : pzv_mem_port

// file: rtl/pzv_irq.sv
// Sticky interrupt status with enable and write-one-to-clear
`timescale 1ns/1ps
module pzv_irq
  import pzv_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [IRQ_W-1:0] set,
  input wire logic [IRQ_W-1:0] clr,
  input wire logic [IRQ_W-1:0] en,
  output logic [IRQ_W-1:0] stat_r,
  output logic irq_r
);
  logic [IRQ_W-1:0] stat_nxt;
  // Set wins over a clear in the same cycle
  assign stat_nxt = (stat_r & ~clr) | set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= '0;
      irq_r <= 1'b0;
    end else if (ce) begin
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & en);
    end
  end
endmodule : pzv_irq

// file: rtl/pzv_vector_unit.sv
// Top: page zero exception vectoring unit with AXI4-Lite control registers
`timescale 1ns/1ps
module pzv_vector_unit
  import pzv_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Event request from the pipeline
  input wire logic ev_valid,
  input wire logic [3:0] ev_code,
  input wire logic [2:0] pc_ring,
  input wire logic [2:0] call_ring,
  input wire logic [31:0] cur_sp,
  input wire logic [15:0] intr_level,
  input wire logic vec_valid,
  input wire logic [4:0] arith_flags,
  output logic ev_ready_r,
  output logic br_valid_r,
  output logic [31:0] br_target_r,
  output logic [31:0] sp_out_r,
  output logic sp_load_r,
  output logic [31:0] icb_ptr_r,
  output logic [31:0] ioreg_ptr_r,
  output logic [4:0] status_arith_r,
  output logic ev_refused_r,
  // Memory master
  output logic mem_req_r,
  output logic mem_we_r,
  output logic [31:0] mem_addr_r,
  output logic [31:0] mem_wdata_r,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_r
);
  // ==========================================================
  // Sequencer state
  typedef enum logic [2:0] {
    PZV_IDLE = 3'b000,
    PZV_SAVE = 3'b001,
    PZV_FETCH = 3'b011,
    PZV_DONE = 3'b010,
    PZV_REFUSE = 3'b110
  } pzv_state_t;

  pzv_state_t state_r;
  pzv_event_t ev_r;
  logic [2:0] ring_r;
  logic [11:0] ofs_r;
  logic [31:0] sp_r;
  logic [2:0] caller_r;
  logic first_intr_r;
  logic [2:0] ctrl_r;
  logic [31:0] isp_r;
  logic [31:0] last_addr_r;
  logic [31:0] last_tgt_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_stat;
  logic [11:0] sel_ofs;
  logic [2:0] sel_ring;
  logic sel_ok;
  logic sel_save;
  logic accept;

  pzv_mem_if mif ();

  pzv_mem_port u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .mif(mif),
    .mem_req_r(mem_req_r),
    .mem_we_r(mem_we_r),
    .mem_addr_r(mem_addr_r),
    .mem_wdata_r(mem_wdata_r),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  pzv_irq u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .set(irq_set),
    .clr(irq_clr),
    .en(irq_en_r),
    .stat_r(irq_stat),
    .irq_r(irq_r)
  );

  // ==========================================================
  // Event decode: chooses the vector page slot and page ring
  always_comb begin
    sel_ofs = OFS_SYSEXC;
    sel_ring = pc_ring;
    sel_ok = 1'b1;
    sel_save = 1'b0;
    case (pzv_event_t'(ev_code))
      PZV_EV_INTR: begin
        sel_ofs = OFS_MP_INTR;
        sel_ring = 3'h0;
        sel_ok = ctrl_r[CTRL_MP];
        sel_save = (intr_level == 16'h0);
      end
      PZV_EV_SYSEXC: sel_ofs = OFS_SYSEXC;
      PZV_EV_DEADLOCK: begin
        sel_ofs = OFS_DEADLOCK;
        sel_ok = ctrl_r[CTRL_MP];
      end
      PZV_EV_VVALID: begin
        sel_ofs = OFS_VVALID;
        sel_ok = !vec_valid;
      end
      PZV_EV_HARDERR: begin
        sel_ofs = OFS_HARDERR;
        sel_ok = ctrl_r[CTRL_MP] && ctrl_r[CTRL_HARDERR];
      end
      PZV_EV_TRACE: sel_ofs = OFS_TRACE;
      PZV_EV_ARITH: sel_ofs = OFS_ARITH;
      PZV_EV_BKPT: sel_ofs = OFS_BKPT;
      PZV_EV_XCALL: begin
        sel_ofs = OFS_GATE;
        sel_ring = call_ring;
        sel_save = 1'b1;
      end
      default: sel_ok = 1'b0;
    endcase
    if (sel_ring > MAX_RING) begin
      sel_ok = 1'b0;
    end
    // Ring 0 only slots are reserved for every other ring
    if (pzv_ring0_only(sel_ofs) && sel_ring != 3'h0) begin
      sel_ok = 1'b0;
    end
  end

  assign accept = ev_valid && ev_ready_r;

  // ==========================================================
  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= PZV_IDLE;
      ev_r <= PZV_EV_NONE;
      ring_r <= 3'h0;
      ofs_r <= 12'h0;
      sp_r <= 32'h0;
      caller_r <= 3'h0;
      first_intr_r <= 1'b0;
      ev_ready_r <= 1'b0;
    end else if (ce) begin
      case (state_r)
        PZV_IDLE: begin
          ev_ready_r <= 1'b1;
          if (accept) begin
            ev_ready_r <= 1'b0;
            ev_r <= pzv_event_t'(ev_code);
            ring_r <= sel_ring;
            ofs_r <= sel_ofs;
            sp_r <= cur_sp;
            caller_r <= pc_ring;
            first_intr_r <= sel_save && (pzv_event_t'(ev_code) == PZV_EV_INTR);
            if (!sel_ok) begin
              state_r <= PZV_REFUSE;
            end else if (sel_save) begin
              state_r <= PZV_SAVE;
            end else begin
              state_r <= PZV_FETCH;
            end
          end
        end
        PZV_SAVE: begin
          if (mif.done) begin
            state_r <= PZV_FETCH;
          end
        end
        PZV_FETCH: begin
          if (mif.done) begin
            state_r <= PZV_DONE;
          end
        end
        PZV_DONE: state_r <= PZV_IDLE;
        PZV_REFUSE: state_r <= PZV_IDLE;
        default: state_r <= PZV_IDLE;
      endcase
    end
  end

  // Memory requests: save slot write first, then pointer read
  always_comb begin
    mif.req = (state_r == PZV_SAVE || state_r == PZV_FETCH) && !mif.done;
    mif.we = (state_r == PZV_SAVE);
    mif.wdata = sp_r;
    if (state_r == PZV_SAVE) begin
      if (first_intr_r) begin
        mif.addr = pzv_page_addr(3'h0, OFS_PREV_SP);
      end else begin
        mif.addr = pzv_page_addr(caller_r, OFS_XRING_SP);
      end
    end else begin
      mif.addr = pzv_page_addr(ring_r, ofs_r);
    end
  end

  // ==========================================================
  // Branch and side outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      br_valid_r <= 1'b0;
      br_target_r <= 32'h0;
      sp_load_r <= 1'b0;
      sp_out_r <= 32'h0;
      ev_refused_r <= 1'b0;
      status_arith_r <= 5'h0;
      last_addr_r <= 32'h0;
      last_tgt_r <= 32'h0;
    end else if (ce) begin
      br_valid_r <= 1'b0;
      sp_load_r <= 1'b0;
      ev_refused_r <= (state_r == PZV_REFUSE);
      if (accept && sel_ok && pzv_event_t'(ev_code) == PZV_EV_ARITH) begin
        status_arith_r <= status_arith_r | arith_flags;
      end
      if (state_r == PZV_FETCH && mif.done) begin
        br_valid_r <= 1'b1;
        br_target_r <= mif.rdata;
        last_addr_r <= pzv_page_addr(ring_r, ofs_r);
        last_tgt_r <= mif.rdata;
        if (first_intr_r) begin
          sp_load_r <= 1'b1;
          sp_out_r <= isp_r;
        end
      end
    end
  end

  // Context pointers give the ring 0 addresses of slots 14 and 18 while enabled in CTRL
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icb_ptr_r <= 32'h0;
      ioreg_ptr_r <= 32'h0;
    end else if (ce) begin
      if (ctrl_r[CTRL_MP]) begin
        icb_ptr_r <= pzv_page_addr(3'h0, OFS_ICB);
      end else begin
        icb_ptr_r <= 32'h0;
      end
      if (ctrl_r[CTRL_MP] && ctrl_r[CTRL_IOREG]) begin
        ioreg_ptr_r <= pzv_page_addr(3'h0, OFS_IOREG);
      end else begin
        ioreg_ptr_r <= 32'h0;
      end
    end
  end

  assign irq_set = {state_r == PZV_REFUSE, state_r == PZV_FETCH && mif.done};

  // ==========================================================
  // AXI4-Lite slave: write path takes address and data in either order
  logic aw_have_r;
  logic w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;

  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_r)
          REG_CTRL, REG_IRQ_EN, REG_IRQ_CLR, REG_ISP: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes honour only byte lane 0 for narrow fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RESET;
      irq_en_r <= '0;
      isp_r <= 32'h0;
    end else if (ce && wr_go) begin
      if (aw_addr_r == REG_CTRL && w_strb_r[0]) begin
        ctrl_r <= w_data_r[2:0];
      end
      if (aw_addr_r == REG_IRQ_EN && w_strb_r[0]) begin
        irq_en_r <= w_data_r[IRQ_W-1:0];
      end
      if (aw_addr_r == REG_ISP) begin
        for (int i = 0; i < 4; i++) begin
          if (w_strb_r[i]) begin
            isp_r[i*8 +: 8] <= w_data_r[i*8 +: 8];
          end
        end
      end
    end
  end

  assign irq_clr = (ce && wr_go && aw_addr_r == REG_IRQ_CLR && w_strb_r[0]) ? w_data_r[IRQ_W-1:0] : '0;

  // Read path: one read at a time, answer on the edge that accepts the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          REG_CTRL: s_axi_rdata <= {29'h0, ctrl_r};
          REG_STATUS: s_axi_rdata <= {24'h0, status_arith_r, state_r};
          REG_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat};
          REG_IRQ_EN: s_axi_rdata <= {30'h0, irq_en_r};
          REG_IRQ_CLR: s_axi_rdata <= 32'h0;
          REG_LAST_ADDR: s_axi_rdata <= last_addr_r;
          REG_LAST_TGT: s_axi_rdata <= last_tgt_r;
          REG_ISP: s_axi_rdata <= isp_r;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : pzv_vector_unit

// file: dv/pzv_checker.sv
// Checker: port-level assertions for the vector unit
`timescale 1ns/1ps
module pzv_checker
  import pzv_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic ev_valid,
  input wire logic [3:0] ev_code,
  input wire logic [2:0] pc_ring,
  input wire logic [2:0] call_ring,
  input wire logic [31:0] cur_sp,
  input wire logic [15:0] intr_level,
  input wire logic vec_valid,
  input wire logic [4:0] arith_flags,
  input wire logic ev_ready_r,
  input wire logic br_valid_r,
  input wire logic [31:0] br_target_r,
  input wire logic sp_load_r,
  input wire logic ev_refused_r,
  input wire logic [4:0] status_arith_r,
  input wire logic mem_req_r,
  input wire logic mem_we_r,
  input wire logic [31:0] mem_addr_r,
  input wire logic [31:0] mem_wdata_r,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  localparam logic [11:0] FT [10] = '{12'h000, OFS_MP_INTR, OFS_SYSEXC, OFS_DEADLOCK, OFS_VVALID,
    OFS_HARDERR, OFS_TRACE, OFS_ARITH, OFS_BKPT, OFS_GATE};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Payload of the event in flight, kept because the pipeline may move on
  logic tk;
  logic [3:0] c_r;
  logic [2:0] r_r;
  logic [2:0] k_r;
  logic [2:0] fr;
  logic [31:0] sp_r;
  logic [4:0] f_r;
  logic z_r;
  assign tk = ev_valid && ev_ready_r && ce;
  assign fr = (c_r == 4'h1) ? 3'h0 : ((c_r == 4'h9) ? k_r : r_r);
  always_ff @(posedge aclk) begin
    if (tk) begin
      c_r <= ev_code;
      r_r <= pc_ring;
      k_r <= call_ring;
      sp_r <= cur_sp;
      f_r <= arith_flags;
      z_r <= (intr_level == 16'h0);
    end
  end
  // ==========================================================
  // Properties
  sequence s_fetch_ack;
    mem_req_r && mem_ack && !mem_we_r;
  endsequence
  sequence s_branch;
    ##2 (br_valid_r && br_target_r == $past(mem_rdata, 2));
  endsequence
  a_mem_hold: assert property (ce && mem_req_r && !mem_ack |=>
    mem_req_r && $stable(mem_addr_r) && $stable(mem_we_r) && $stable(mem_wdata_r))
    else $error("memory request changed before ack");
  a_fetch_slot: assert property (mem_req_r && !mem_we_r |-> mem_addr_r == {fr, 17'h0, FT[c_r]})
    else $error("fetch from wrong slot");
  a_save_slot: assert property (mem_req_r && mem_we_r |-> mem_wdata_r == sp_r &&
    mem_addr_r == ((c_r == 4'h9) ? {r_r, 17'h0, OFS_XRING_SP} : {20'h0, OFS_PREV_SP}))
    else $error("stack save wrong");
  a_ring0_low: assert property (mem_req_r && mem_addr_r[11:0] <= OFS_RING0_TOP |-> mem_addr_r[31:29] == 3'h0)
    else $error("low slot used outside ring 0");
  a_sw_free: assert property (mem_req_r |-> mem_addr_r[11:0] <= OFS_BKPT && mem_addr_r[28:12] == 17'h0)
    else $error("software area touched");
  a_target: assert property (s_fetch_ack |-> s_branch)
    else $error("target not the fetched pointer");
  a_vv_refuse: assert property (tk && ev_code == 4'h4 && vec_valid |-> ##2 ev_refused_r)
    else $error("vector valid trap not refused");
  a_arith_or: assert property (br_valid_r && c_r == 4'h7 |-> (status_arith_r & f_r) == f_r)
    else $error("arith flags not kept");
  a_sp_load: assert property (sp_load_r |-> br_valid_r && c_r == 4'h1 && z_r)
    else $error("stack load without first interrupt");
endmodule : pzv_checker
bind pzv_vector_unit pzv_checker u_chk (.*);

// file: dv/tb.sv
// Testbench: self-checking bench for the page zero vector unit
`timescale 1ns/1ps
module tb
  import pzv_pkg::*;
;
  localparam logic [11:0] FT [10] = '{12'h000, OFS_MP_INTR, OFS_SYSEXC, OFS_DEADLOCK, OFS_VVALID,
    OFS_HARDERR, OFS_TRACE, OFS_ARITH, OFS_BKPT, OFS_GATE};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic ev_valid = 1'b0;
  logic vec_valid = 1'b0;
  logic [3:0] ev_code = 4'h0;
  logic [2:0] pc_ring = 3'h0;
  logic [2:0] call_ring = 3'h0;
  logic [31:0] cur_sp = 32'h0;
  logic [15:0] intr_level = 16'h0;
  logic [4:0] arith_flags = 5'h0;
  logic ev_ready_r, br_valid_r, sp_load_r, ev_refused_r, irq_r, mem_req_r, mem_we_r;
  logic [31:0] br_target_r, sp_out_r, icb_ptr_r, ioreg_ptr_r, mem_addr_r, mem_wdata_r;
  logic [4:0] status_arith_r;
  logic mem_ack = 1'b0;
  logic [31:0] mem_rdata = 32'h0;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int bad_count = 0;
  int compares = 0;
  int wr_cnt = 0;
  logic [31:0] wr_a, wr_d, d, isp;
  logic [31:0] seed = 32'h4F;
  logic [31:0] rs = 32'h4F;
  logic [1:0] rp;
  logic [1:0] dly = 2'h0;
  logic [2:0] ctl = 3'h0;
  logic [4:0] ar_acc = 5'h0;
  pzv_vector_unit u_dut (.*);
  always #12.5 aclk = ~aclk;
  // ==========================================================
  // Expectations
  function automatic logic [31:0] nx(input logic [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  function automatic logic [31:0] pa(input logic [2:0] r, input logic [11:0] o);
    pa = {r, 17'h0, o};
  endfunction : pa
  function automatic logic [31:0] tg(input logic [31:0] a);
    tg = a ^ 32'h13579BDF;
  endfunction : tg
  function automatic logic rf(input logic [3:0] c, input logic [2:0] r, k, input logic v);
    logic [2:0] e;
    e = (c == 4'h1) ? 3'h0 : ((c == 4'h9) ? k : r);
    rf = c == 4'h0 || c > 4'h9 || e > 3'h4 || (c inside {[4'h2:4'h5]} && r != 3'h0) ||
      (c inside {4'h1, 4'h3} && !ctl[0]) || (c == 4'h4 && v) || (c == 4'h5 && !(ctl[0] && ctl[2]));
  endfunction : rf
  // ==========================================================
  // Memory side: random latency, data line churns while not acked
  always @(posedge aclk) begin
    rs <= nx(rs);
    if (!mem_ack && mem_req_r && dly == 2'h0) begin
      mem_ack <= 1'b1;
      mem_rdata <= tg(mem_addr_r);
      dly <= rs[1:0];
      if (mem_we_r) begin
        wr_cnt <= wr_cnt + 1;
        wr_a <= mem_addr_r;
        wr_d <= mem_wdata_r;
      end
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req_r && !mem_ack) dly <= dly - 2'h1;
    end
  end
  // ==========================================================
  // Tasks
  task automatic stop_test;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic tmo(input string m);
    bad_count++;
    $display("CHECK FAILED t=%0t timeout %s", $time, m);
    stop_test();
  endtask : tmo
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
    int n;
    logic ad, wd, bd;
    {ad, wd, bd} = 3'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= dv;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100 && !bd; n++) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        bd = 1'b1;
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er, "bresp");
      end
    end
    if (!bd) tmo("write");
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] r);
    int n;
    logic ad, rd;
    {ad, rd} = 2'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100 && !rd; n++) begin
      @(posedge aclk);
      if (!ad && s_axi_arready) begin
        ad = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        rd = 1'b1;
        dv = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (!rd) tmo("read");
  endtask : axi_rd
  task automatic ev(input logic [3:0] c, input logic [2:0] r, k, input logic [15:0] l, input logic v,
    input logic [4:0] f);
    int n, w0;
    logic sv, xr;
    logic [31:0] sp;
    sp = seed;
    seed = nx(seed);
    xr = rf(c, r, k, v);
    sv = (c == 4'h1 && l == 16'h0) || c == 4'h9;
    @(posedge aclk);
    ev_valid <= 1'b1;
    ev_code <= c;
    pc_ring <= r;
    call_ring <= k;
    cur_sp <= sp;
    intr_level <= l;
    vec_valid <= v;
    arith_flags <= f;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (ev_ready_r) break;
    end
    if (n == 100) tmo("take");
    ev_valid <= 1'b0;
    cur_sp <= ~sp;
    arith_flags <= ~f;
    w0 = wr_cnt;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      #1;
      if (br_valid_r || ev_refused_r) break;
    end
    if (n == 200) tmo("answer");
    chk(ev_refused_r, xr, "refused");
    if (!xr) begin
      chk(br_target_r, tg(pa((c == 4'h1) ? 3'h0 : ((c == 4'h9) ? k : r), FT[c])), "target");
      chk(32'(wr_cnt - w0), sv, "saves");
      chk(sp_load_r, c == 4'h1 && l == 16'h0, "sp load");
      if (sv) chk(wr_a, (c == 4'h9) ? pa(r, OFS_XRING_SP) : pa(3'h0, OFS_PREV_SP), "save addr");
      if (sv) chk(wr_d, sp, "save data");
      if (c == 4'h7) ar_acc = ar_acc | f;
    end
    chk(status_arith_r, ar_acc, "arith");
  endtask : ev
  // ==========================================================
  // Main sequence
  initial begin
    isp = 32'h00A01000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(REG_CTRL, d, rp);
    chk(d, 32'(CTRL_RESET), "ctrl reset");
    axi_rd(REG_IRQ_STAT, d, rp);
    chk(d, 32'h0, "stat reset");
    axi_rd(8'h20, d, rp);
    chk({rp, d}, {RESP_SLVERR, 32'h0}, "unmapped read");
    axi_wr(8'h24, 32'h1, RESP_SLVERR);
    axi_wr(REG_ISP, isp, RESP_OKAY);
    axi_wr(REG_IRQ_EN, 32'h3, RESP_OKAY);
    ev(4'h1, 3'h0, 3'h0, 16'h0, 1'b0, 5'h0);
    ev(4'h3, 3'h0, 3'h0, 16'h0, 1'b0, 5'h0);
    ev(4'h5, 3'h0, 3'h0, 16'h0, 1'b0, 5'h0);
    chk(icb_ptr_r, 32'h0, "icb off");
    chk(ioreg_ptr_r, 32'h0, "ioreg off");
    ctl = 3'h7;
    axi_wr(REG_CTRL, 32'h7, RESP_OKAY);
    axi_rd(REG_CTRL, d, rp);
    chk(d, 32'h7, "ctrl");
    chk(icb_ptr_r, pa(3'h0, OFS_ICB), "icb");
    chk(ioreg_ptr_r, pa(3'h0, OFS_IOREG), "ioreg");
    for (int c = 1; c <= 9; c++) ev(4'(c), 3'h0, 3'h4, 16'h0, 1'b0, 5'h15);
    chk(sp_out_r, isp, "isp");
    chk(irq_r, 1'b1, "irq up");
    ev(4'h1, 3'h2, 3'h0, 16'h3, 1'b0, 5'h0);
    ev(4'h2, 3'h3, 3'h0, 16'h0, 1'b0, 5'h0);
    ev(4'h4, 3'h0, 3'h0, 16'h0, 1'b1, 5'h0);
    ev(4'h6, 3'h5, 3'h0, 16'h0, 1'b0, 5'h0);
    ev(4'hA, 3'h0, 3'h0, 16'h0, 1'b0, 5'h0);
    ev(4'h9, 3'h4, 3'h1, 16'h0, 1'b0, 5'h0);
    axi_rd(REG_LAST_ADDR, d, rp);
    chk(d, pa(3'h1, OFS_GATE), "last addr");
    axi_rd(REG_LAST_TGT, d, rp);
    chk(d, tg(pa(3'h1, OFS_GATE)), "last tgt");
    axi_rd(REG_IRQ_STAT, d, rp);
    chk(d, 32'h3, "irq stat");
    axi_wr(REG_IRQ_EN, 32'h0, RESP_OKAY);
    #1;
    chk(irq_r, 1'b0, "irq masked");
    axi_wr(REG_IRQ_EN, 32'h3, RESP_OKAY);
    axi_wr(REG_IRQ_CLR, 32'h3, RESP_OKAY);
    axi_rd(REG_IRQ_STAT, d, rp);
    chk({irq_r, d}, 33'h0, "irq clear");
    repeat (40) begin
      d = seed;
      seed = nx(seed);
      ev(4'(d[3:0] % 9 + 1), (d[3:0] % 9 == 0) ? 3'h1 : d[6:4], 3'(d[9:7] % 5), {15'h0, d[10]}, d[11],
        d[16:12]);
    end
    stop_test();
  end
endmodule : tb
